//--- src/ric_pkg.sv
package ric_pkg;
  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_INT_SRC_CFG = 8'h14;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h15;
  localparam logic [7:0] OFS_RESET_DETECT = 8'h16;
  localparam logic [7:0] OFS_PARAM_HOLD = 8'h17;
  localparam logic [7:0] OFS_RANGE_START = 8'h18;
  localparam logic [7:0] OFS_RANGE_UPPER = 8'h19;
  localparam logic [7:0] OFS_RANGE_LOWER = 8'h1A;
  localparam logic [7:0] OFS_REPEAT_PERIOD = 8'h1B;
  localparam logic [7:0] OFS_TIME_LIMIT = 8'h1C;
  localparam logic [7:0] OFS_LEAK_RATE_HI = 8'h1E;
  localparam logic [7:0] OFS_LEAK_RATE_LO = 8'h1F;
  localparam logic [7:0] OFS_LEAK_MIN_HT = 8'h21;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int RANGE_MODE_LSB = 0;
  localparam int ALS_MODE_LSB = 3;
  localparam int CLR_RANGE_BIT = 0;
  localparam int CLR_ALS_BIT = 1;
  localparam int CLR_ERR_BIT = 2;
  localparam int START_BIT = 0;
  localparam int MODE_SEL_BIT = 1;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [5:0] RST_INT_SRC_CFG = 6'h00;
  localparam logic RST_RESET_DETECT = 1'b1;
  localparam logic [7:0] RST_RANGE_UPPER = 8'hFF;
  localparam logic [7:0] RST_RANGE_LOWER = 8'h00;
  localparam logic [7:0] RST_REPEAT_PERIOD = 8'hFF;
  localparam logic [5:0] RST_TIME_LIMIT = 6'h31;
  localparam logic [15:0] RST_LEAK_RATE = 16'h0000;
  localparam logic [7:0] RST_LEAK_MIN_HT = 8'h14;

  // ------------------------------------------------------------------
  // Interrupt source modes and pin function
  // ------------------------------------------------------------------
  localparam logic [2:0] IMODE_OFF = 3'h0;
  localparam logic [2:0] IMODE_LOW = 3'h1;
  localparam logic [2:0] IMODE_HIGH = 3'h2;
  localparam logic [2:0] IMODE_WINDOW = 3'h3;
  localparam logic [2:0] IMODE_SAMPLE = 3'h4;
  localparam logic [3:0] PIN_FUNC_INT = 4'h8;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [11:0] REPEAT_STEP_MS = 12'h00A;

  typedef enum logic [2:0] {
    RIC_IDLE = 3'b001,
    RIC_MEAS = 3'b010,
    RIC_WAIT = 3'b100
  } ric_state_e;
endpackage : ric_pkg

//--- src/ric_ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ric_ms_timer #(
  parameter int CYC_PER_MS = ric_pkg::CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic stop,
  input wire logic [11:0] load_ms,
  output logic expired
);
  import ric_pkg::*;

  logic [31:0] pre_q;
  logic [11:0] ms_q;
  logic run_q;
  logic tick;

  assign tick = (pre_q == 32'(CYC_PER_MS - 1));

  // Prescaler restarts on every load so each millisecond is whole.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q <= 32'h0;
    end else if (load || tick || !run_q) begin
      pre_q <= 32'h0;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ms_q <= 12'h000;
      run_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        ms_q <= load_ms;
        run_q <= 1'b1;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q && tick) begin
        ms_q <= ms_q - 12'h1;
        if (ms_q == 12'h1) begin
          run_q <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end
endmodule // ric_ms_timer
`default_nettype wire

//--- src/ric_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ric_ctrl #(
  parameter int CYC_PER_MS = ric_pkg::CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic meas_start,
  output logic meas_abort,
  input wire logic meas_done,
  input wire logic [7:0] meas_range,
  input wire logic als_sample,
  input wire logic als_below_low,
  input wire logic als_above_high,
  input wire logic err_event,
  input wire logic [3:0] int_pin_func,
  input wire logic int_pin_polarity,
  output logic int_pin_o,
  output logic int_pin_oe_n,
  output logic ranging_busy,
  output logic fw_copy_ok,
  output logic [7:0] upper_limit_act,
  output logic [15:0] leak_rate,
  output logic leak_apply,
  output logic [2:0] int_pending
);
  import ric_pkg::*;

  default clocking ric_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [5:0] int_cfg_q, int_cfg_act_q, tlimit_q;
  logic [7:0] upper_q, lower_q, period_q, leak_ht_q;
  logic [15:0] leak_rate_q;
  logic [2:0] pend_q;
  logic [11:0] tmr_ms;
  logic reset_detect_q, hold_q, start_q, mode_q, cont_run_q;
  logic wr_clear, start_ack, tmr_load, tmr_stop, tmr_exp;
  logic range_hit, als_hit, sample_end;
  ric_state_e state_q;

  assign wr_clear = reg_wr && (reg_addr == OFS_INT_CLEAR);

  // ------------------------------------------------------------------
  // Host writes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_cfg_q <= RST_INT_SRC_CFG;
      hold_q <= 1'b0;
      mode_q <= 1'b0;
      upper_q <= RST_RANGE_UPPER;
      lower_q <= RST_RANGE_LOWER;
      period_q <= RST_REPEAT_PERIOD;
      tlimit_q <= RST_TIME_LIMIT;
      leak_rate_q <= RST_LEAK_RATE;
      leak_ht_q <= RST_LEAK_MIN_HT;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_INT_SRC_CFG: int_cfg_q <= reg_wdata[5:0];
        OFS_PARAM_HOLD: hold_q <= reg_wdata[0];
        OFS_RANGE_START: mode_q <= reg_wdata[MODE_SEL_BIT];
        OFS_RANGE_UPPER: upper_q <= reg_wdata;
        OFS_RANGE_LOWER: lower_q <= reg_wdata;
        OFS_REPEAT_PERIOD: period_q <= reg_wdata;
        OFS_TIME_LIMIT: tlimit_q <= reg_wdata[5:0];
        OFS_LEAK_RATE_HI: leak_rate_q[15:8] <= reg_wdata;
        OFS_LEAK_RATE_LO: leak_rate_q[7:0] <= reg_wdata;
        OFS_LEAK_MIN_HT: leak_ht_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_detect_q <= RST_RESET_DETECT;
    end else if (reg_wr && (reg_addr == OFS_RESET_DETECT)) begin
      reset_detect_q <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else if (reg_wr && (reg_addr == OFS_RANGE_START) && reg_wdata[START_BIT]) begin
      start_q <= 1'b1;
    end else if (start_ack) begin
      start_q <= 1'b0;
    end
  end

  assign start_ack = start_q;

  // ------------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_INT_SRC_CFG: reg_rdata <= {2'b00, int_cfg_q};
        OFS_INT_CLEAR: reg_rdata <= 8'h00;
        OFS_RESET_DETECT: reg_rdata <= {7'h00, reset_detect_q};
        OFS_PARAM_HOLD: reg_rdata <= {7'h00, hold_q};
        OFS_RANGE_START: reg_rdata <= {6'h00, mode_q, start_q};
        OFS_RANGE_UPPER: reg_rdata <= upper_q;
        OFS_RANGE_LOWER: reg_rdata <= lower_q;
        OFS_REPEAT_PERIOD: reg_rdata <= period_q;
        OFS_TIME_LIMIT: reg_rdata <= {2'b00, tlimit_q};
        OFS_LEAK_RATE_HI: reg_rdata <= leak_rate_q[15:8];
        OFS_LEAK_RATE_LO: reg_rdata <= leak_rate_q[7:0];
        OFS_LEAK_MIN_HT: reg_rdata <= leak_ht_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Grouped settings
  // ------------------------------------------------------------------
  // copy only when released
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_cfg_act_q <= RST_INT_SRC_CFG;
      upper_limit_act <= RST_RANGE_UPPER;
    end else if (meas_start && !hold_q) begin
      int_cfg_act_q <= int_cfg_q;
      upper_limit_act <= upper_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fw_copy_ok <= 1'b1;
    end else begin
      fw_copy_ok <= !hold_q;
    end
  end

  // ------------------------------------------------------------------
  // Ranging sequencer
  // ------------------------------------------------------------------
  // repeat delay in ms
  // time limit, zero taken as 1 ms
  always_comb begin
    tmr_load = 1'b0;
    tmr_ms = 12'h000;
    if (state_q == RIC_IDLE && start_ack && (!mode_q || !cont_run_q)) begin
      tmr_load = 1'b1;
      tmr_ms = (tlimit_q == 6'h00) ? 12'h001 : {6'h00, tlimit_q};
    end else if (state_q == RIC_WAIT && tmr_exp) begin
      tmr_load = 1'b1;
      tmr_ms = (tlimit_q == 6'h00) ? 12'h001 : {6'h00, tlimit_q};
    end else if (state_q == RIC_MEAS && (meas_done || tmr_exp) && cont_run_q) begin
      tmr_load = 1'b1;
      tmr_ms = 12'(({4'h0, period_q} + 12'h001) * REPEAT_STEP_MS);
    end
  end

  assign tmr_stop = (state_q == RIC_MEAS) && meas_done && !cont_run_q;

  ric_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (.clk_sys(clk_sys), .rst(rst), .load(tmr_load),
    .stop(tmr_stop), .load_ms(tmr_ms), .expired(tmr_exp));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= RIC_IDLE;
      cont_run_q <= 1'b0;
      meas_start <= 1'b0;
      meas_abort <= 1'b0;
      ranging_busy <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      meas_abort <= 1'b0;
      ranging_busy <= (state_q != RIC_IDLE) || cont_run_q;
      if (start_ack && mode_q && cont_run_q) begin
        cont_run_q <= 1'b0;
      end
      case (state_q)
        RIC_IDLE: begin
          if (start_ack && (!mode_q || !cont_run_q)) begin
            cont_run_q <= mode_q;
            meas_start <= 1'b1;
            state_q <= RIC_MEAS;
          end
        end
        RIC_MEAS: begin
          if (meas_done || tmr_exp) begin
            meas_abort <= !meas_done;
            state_q <= (cont_run_q && !(start_ack && mode_q)) ? RIC_WAIT : RIC_IDLE;
          end
        end
        RIC_WAIT: begin
          if (start_ack && mode_q) begin
            state_q <= RIC_IDLE;
          end else if (tmr_exp) begin
            meas_start <= 1'b1;
            state_q <= RIC_MEAS;
          end
        end
        default: state_q <= RIC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Interrupt sources
  // ------------------------------------------------------------------
  assign sample_end = (state_q == RIC_MEAS) && meas_done;

  always_comb begin
    case (int_cfg_act_q[RANGE_MODE_LSB +: 3])
      IMODE_LOW: range_hit = meas_range < lower_q;
      IMODE_HIGH: range_hit = meas_range > upper_limit_act;
      IMODE_WINDOW: range_hit = (meas_range < lower_q) || (meas_range > upper_limit_act);
      IMODE_SAMPLE: range_hit = 1'b1;
      default: range_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (int_cfg_act_q[ALS_MODE_LSB +: 3])
      IMODE_LOW: als_hit = als_below_low;
      IMODE_HIGH: als_hit = als_above_high;
      IMODE_WINDOW: als_hit = als_below_low || als_above_high;
      IMODE_SAMPLE: als_hit = 1'b1;
      default: als_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q <= 3'h0;
    end else begin
      pend_q[CLR_RANGE_BIT] <= (sample_end && range_hit) ||
        (pend_q[CLR_RANGE_BIT] && !(wr_clear && reg_wdata[CLR_RANGE_BIT]));
      pend_q[CLR_ALS_BIT] <= (als_sample && als_hit) ||
        (pend_q[CLR_ALS_BIT] && !(wr_clear && reg_wdata[CLR_ALS_BIT]));
      pend_q[CLR_ERR_BIT] <= err_event ||
        (pend_q[CLR_ERR_BIT] && !(wr_clear && reg_wdata[CLR_ERR_BIT]));
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_pending <= 3'h0;
      int_pin_o <= 1'b0;
      int_pin_oe_n <= 1'b1;
    end else begin
      int_pending <= pend_q;
      int_pin_oe_n <= (int_pin_func != PIN_FUNC_INT);
      int_pin_o <= (|pend_q) ? int_pin_polarity : !int_pin_polarity;
    end
  end

  // ------------------------------------------------------------------
  // Leakage compensation
  // ------------------------------------------------------------------
  // rate output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      leak_rate <= RST_LEAK_RATE;
      leak_apply <= 1'b0;
    end else begin
      leak_rate <= leak_rate_q;
      if (sample_end) begin
        leak_apply <= meas_range >= leak_ht_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_start_write;
    reg_wr && reg_addr == OFS_RANGE_START && reg_wdata[START_BIT];
  endsequence

  property p_start_clear;
    s_start_write ##1 start_q |=> !start_q;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");
  property p_single_one;
    (state_q == RIC_IDLE && start_ack && !mode_q) |=> meas_start ##1 !meas_start;
  endproperty
  a_single_one: assert property (p_single_one) else $error("single shot launch wrong");
  property p_cont_halt;
    (start_ack && mode_q && cont_run_q && state_q == RIC_WAIT) |=> state_q == RIC_IDLE && !cont_run_q;
  endproperty
  a_cont_halt: assert property (p_cont_halt) else $error("continuous halt failed");
  property p_mode_sel;
    (state_q == RIC_IDLE && start_ack && mode_q && !cont_run_q) |=> cont_run_q;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("continuous not entered");
  property p_sticky;
    (pend_q[CLR_ERR_BIT] && !(wr_clear && reg_wdata[CLR_ERR_BIT])) |=> pend_q[CLR_ERR_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("error interrupt dropped");
  property p_clear;
    (wr_clear && reg_wdata[CLR_RANGE_BIT] && !sample_end) |=> !pend_q[CLR_RANGE_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("range interrupt not cleared");
  property p_hold;
    (meas_start && hold_q) |=> $stable(upper_limit_act);
  endproperty
  a_hold: assert property (p_hold) else $error("settings copied under hold");
  property p_reset_detect;
    (reg_wr && reg_addr == OFS_RESET_DETECT) |=> reset_detect_q == $past(reg_wdata[0]);
  endproperty
  a_reset_detect: assert property (p_reset_detect) else $error("reset flag not written");
  property p_pin;
    (int_pin_func == PIN_FUNC_INT) ##1 (int_pin_func == PIN_FUNC_INT) |-> !int_pin_oe_n;
  endproperty
  a_pin: assert property (p_pin) else $error("interrupt pin not driven");
  property p_leak;
    sample_end |=> leak_apply == ($past(meas_range) >= leak_ht_q);
  endproperty
  a_leak: assert property (p_leak) else $error("leakage gate wrong");
endmodule // ric_ctrl
`default_nettype wire

//--- tb/ric_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Measurement engine model
// ----------------------------------------
// A response count of zero never finishes, so only the time limit ends the run.
// Outside the result pulse the range shows the inverse of the last result.
module ric_engine_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic meas_start,
  input wire logic meas_abort,
  input wire logic [7:0] resp_cyc,
  input wire logic [7:0] resp_range,
  output logic meas_done,
  output logic [7:0] meas_range
);
  logic busy_q;
  logic [7:0] cnt_q;
  logic [7:0] last_q;
  assign meas_range = meas_done ? last_q : ~last_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      last_q <= 8'h00;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (meas_start) begin
        busy_q <= 1'b1;
        cnt_q <= resp_cyc;
      end else if (meas_abort) begin
        busy_q <= 1'b0;
      end else if (busy_q && resp_cyc != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q <= 8'h01) begin
          busy_q <= 1'b0;
          meas_done <= 1'b1;
          last_q <= resp_range;
        end
      end
    end
  end
endmodule // ric_engine_model
`default_nettype wire

//--- tb/range_interrupt_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module range_interrupt_control_regs_tb;
  import ric_pkg::*;
  localparam int CMS = 10;
  localparam logic [15:0] RST_TAB [14] = '{16'h1400, 16'h1500, 16'h1601, 16'h1700, 16'h1800, 16'h19FF,
    16'h1A00, 16'h1BFF, 16'h1C31, 16'h1D00, 16'h1E00, 16'h1F00, 16'h2000, 16'h2114};
  logic clk_sys, rst, reg_wr, reg_rd, meas_start, meas_abort, meas_done;
  logic als_sample, als_below_low, als_above_high, err_event, int_pin_polarity;
  logic int_pin_o, int_pin_oe_n, ranging_busy, fw_copy_ok, leak_apply, er, ea;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, meas_range, upper_limit_act, resp_cyc, resp_range, lfsr_q, mh;
  logic [3:0] int_pin_func;
  logic [2:0] int_pending, m;
  logic [15:0] leak_rate;
  int n_mismatch, check_count, cyc, b;
  int n_ev [3];
  int t_ev [3];
  ric_ctrl #(.CYC_PER_MS(CMS)) dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_start(meas_start),
    .meas_abort(meas_abort), .meas_done(meas_done), .meas_range(meas_range), .als_sample(als_sample),
    .als_below_low(als_below_low), .als_above_high(als_above_high), .err_event(err_event),
    .int_pin_func(int_pin_func), .int_pin_polarity(int_pin_polarity), .int_pin_o(int_pin_o),
    .int_pin_oe_n(int_pin_oe_n), .ranging_busy(ranging_busy), .fw_copy_ok(fw_copy_ok),
    .upper_limit_act(upper_limit_act), .leak_rate(leak_rate), .leak_apply(leak_apply),
    .int_pending(int_pending));
  ric_engine_model eng (.clk_sys(clk_sys), .rst(rst), .meas_start(meas_start), .meas_abort(meas_abort),
    .resp_cyc(resp_cyc), .resp_range(resp_range), .meas_done(meas_done), .meas_range(meas_range));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (meas_start === 1'b1) begin
      n_ev[0]++;
      t_ev[0] = cyc;
    end
    if (meas_done === 1'b1) begin
      n_ev[1]++;
      t_ev[1] = cyc;
    end
    if (meas_abort === 1'b1) begin
      n_ev[2]++;
      t_ev[2] = cyc;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int seen, input int exp);
    check(16'((seen >= exp - 3) && (seen <= exp + 3)), 16'h0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check(16'(reg_rdata), 16'(exp));
  endtask
  task automatic wait_ev(input int k, input int base);
    for (int i = 0; i < 3000 && n_ev[k] == base; i++) @(negedge clk_sys);
    check(16'(n_ev[k] != base), 16'h0001);
  endtask
  task automatic shot();
    int d;
    d = n_ev[1];
    wr(OFS_RANGE_START, 8'h01);
    wait_ev(1, d);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic hit(input logic [2:0] md, input logic lo, input logic hi);
    case (md)
      IMODE_LOW: return lo;
      IMODE_HIGH: return hi;
      IMODE_WINDOW: return lo | hi;
      IMODE_SAMPLE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_wr, reg_rd, als_sample, als_below_low, als_above_high, err_event} = 6'h00;
    {reg_addr, reg_wdata, resp_range} = 24'h000000;
    int_pin_func = PIN_FUNC_INT;
    int_pin_polarity = 1'b1;
    resp_cyc = 8'h05;
    lfsr_q = 8'h53;
    n_mismatch = 0;
    check_count = 0;
    cyc = 0;
    n_ev = '{0, 0, 0};
    t_ev = '{0, 0, 0};
    rst = 1'b1;
    settle(4);
    rst = 1'b0;
    check({upper_limit_act, leak_rate[7:0]}, 16'hFF00);
    check(16'({int_pin_oe_n, fw_copy_ok, int_pending}), 16'h0018);
    for (int i = 0; i < 14; i++) rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    wr(OFS_RESET_DETECT, 8'h00);
    rd_chk(OFS_RESET_DETECT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(OFS_RANGE_UPPER, lfsr_q);
      rd_chk(OFS_RANGE_UPPER, lfsr_q);
      wr(OFS_RANGE_LOWER, ~lfsr_q);
      rd_chk(OFS_RANGE_LOWER, ~lfsr_q);
      wr(OFS_LEAK_RATE_HI, lfsr_q);
      wr(OFS_LEAK_RATE_LO, lfsr_q ^ 8'h5A);
      settle(2);
      check(leak_rate, {lfsr_q, lfsr_q ^ 8'h5A});
      wr(OFS_TIME_LIMIT, lfsr_q & 8'h3F);
      rd_chk(OFS_TIME_LIMIT, lfsr_q & 8'h3F);
    end
    wr(OFS_RANGE_UPPER, 8'h90);
    shot();
    check(16'(upper_limit_act), 16'h0090);
    wr(OFS_PARAM_HOLD, 8'h01);
    settle(2);
    check(16'(fw_copy_ok), 16'h0000);
    wr(OFS_RANGE_UPPER, 8'h70);
    shot();
    check(16'(upper_limit_act), 16'h0090);
    wr(OFS_PARAM_HOLD, 8'h00);
    shot();
    check({upper_limit_act, 7'h00, fw_copy_ok}, 16'h7001);
    wr(OFS_RANGE_UPPER, 8'hC0);
    wr(OFS_RANGE_LOWER, 8'h40);
    for (int i = 0; i < 10; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      m = 3'(i % 5);
      resp_range = (i < 4) ? 8'(8'h3F + i + (i / 2) * 8'h7E) : lfsr_q;
      mh = i[0] ? lfsr_next(lfsr_q) : resp_range;
      int_pin_polarity = i[1];
      int_pin_func = (i == 3) ? 4'h0 : PIN_FUNC_INT;
      wr(OFS_INT_SRC_CFG, {2'b00, m, m});
      wr(OFS_LEAK_MIN_HT, mh);
      b = n_ev[0];
      shot();
      check(16'(n_ev[0] - b), 16'h0001);
      rd_chk(OFS_RANGE_START, 8'h00);
      er = hit(m, resp_range < 8'h40, resp_range > 8'hC0);
      check(16'(int_pending[0]), 16'(er));
      check(16'(leak_apply), 16'(resp_range >= mh));
      @(negedge clk_sys);
      als_sample = 1'b1;
      als_below_low = lfsr_q[0];
      als_above_high = lfsr_q[1];
      @(negedge clk_sys);
      als_sample = 1'b0;
      err_event = 1'b1;
      @(negedge clk_sys);
      err_event = 1'b0;
      settle(3);
      ea = hit(m, lfsr_q[0], lfsr_q[1]);
      check(16'(int_pending), 16'({1'b1, ea, er}));
      check(16'({int_pin_o, int_pin_oe_n}), 16'({int_pin_polarity, i == 3}));
      wr(OFS_INT_CLEAR, 8'h04);
      settle(2);
      check(16'(int_pending), 16'({1'b0, ea, er}));
      wr(OFS_INT_CLEAR, 8'h03);
      settle(2);
      check(16'({int_pending, int_pin_o}), 16'({3'b000, ~int_pin_polarity}));
    end
    wr(OFS_TIME_LIMIT, 8'h02);
    resp_cyc = 8'h00;
    b = n_ev[2];
    wr(OFS_RANGE_START, 8'h01);
    wait_ev(2, b);
    near(t_ev[2] - t_ev[0], 2 * CMS);
    settle(4);
    check(16'(ranging_busy), 16'h0000);
    resp_cyc = 8'h05;
    for (int p = 0; p < 2; p++) begin
      wr(OFS_REPEAT_PERIOD, 8'(p));
      b = n_ev[0];
      wr(OFS_RANGE_START, 8'h03);
      wait_ev(0, b);
      wait_ev(0, b + 1);
      near(t_ev[0] - t_ev[1], (p + 1) * 10 * CMS);
      check(16'(ranging_busy), 16'h0001);
      b = n_ev[1];
      wait_ev(1, b);
      wr(OFS_RANGE_START, 8'h03);
      b = n_ev[0];
      settle((p + 1) * 10 * CMS + 20);
      check(16'({n_ev[0] - b, 7'h00, ranging_busy}), 16'h0000);
      rd_chk(OFS_RANGE_START, 8'h02);
    end
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    rd_chk(OFS_RESET_DETECT, 8'h01);
    end_of_test();
  end
endmodule // range_interrupt_control_regs_tb
`default_nettype wire
